// ### core/irb_baud_ir.sv
// baud rate generator and infrared pulse control
// assumes the crystal oscillator clock arrives as a slow pin sampled on clock,
// and that the transmitter/receiver consume the 16x tick and ir pulse.
//
// Overview of operation
// - source select 1 picks bus clock, 0 picks crystal oscillator clock.
// - reset clears source select, crystal oscillator drives generator.
// - prescaler code 00/01/10/11 divides by 1/3/4/13.
// - reset clears prescaler field, divisor one.
// - rate divisor equals two to the power of field, 1 to 128.
// - reset clears rate divisor field, divisor one.
// - bit rate is source over 16 times prescaler times rate divisor.
// - one rate setting serves both receiver and transmitter.
// - narrow pulse codes 00/01/11 give 3/16, 1/16, 1/32 bit widths; rate divisor one gives 3/8, 1/8, 1/16.
// - reset clears narrow pulse field, 3/16 width.
// - infrared enable encodes transmit and decodes receive data; clear disables.
// - reset clears infrared enable.
`timescale 1ns/10ps
`default_nettype none
module irb_baud_ir
  import irb_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output var  logic [DATA_W-1:0] reg_rdata,
  input  wire logic              crystal_osc_clock,
  input  wire logic              tx_serial,
  input  wire logic              ir_rx_pin,
  output var  logic              sample_tick,
  output var  logic              bit_tick,
  output var  logic              ir_tx_pin,
  output var  logic              rx_serial
);

  // ==========================================================
  // function: prescaler divisor from its code
  function automatic logic [3:0] pd_of(input logic [1:0] code);
    logic [3:0] r;
    r = PD_CODE0;
    unique case (code)
      2'h0: r = PD_CODE0;
      2'h1: r = PD_CODE1;
      2'h2: r = PD_CODE2;
      2'h3: r = PD_CODE3;
    endcase
    return r;
  endfunction : pd_of

  // function: narrow pulse width in 1/32 bit slots
  function automatic logic [5:0] width_of(input logic [1:0] code);
    logic [5:0] r;
    r = PULSE_3_16;
    unique case (code)
      2'h0: r = PULSE_3_16;
      2'h1: r = PULSE_1_16;
      2'h2: r = PULSE_3_16;
      2'h3: r = PULSE_1_32;
    endcase
    return r;
  endfunction : width_of

  // ==========================================================
  // configuration registers
  logic       clock_source_select;
  logic [1:0] prescaler_select;
  logic [2:0] rate_divisor_select;
  logic [1:0] narrow_pulse_select;
  logic       infrared_enable;

  // software writes; reset zeroes every field
  always_ff @(posedge clock) begin
    if (!resetn) begin
      clock_source_select <= BAUD_RATE_CONFIG_RST[CLK_SRC_BIT];
      prescaler_select    <= BAUD_RATE_CONFIG_RST[PRESCALE_LSB +: 2];
      rate_divisor_select <= BAUD_RATE_CONFIG_RST[RATE_DIV_LSB +: 3];
    end else if (reg_write && reg_addr == BAUD_RATE_CONFIG_OFS) begin
      clock_source_select <= reg_wdata[CLK_SRC_BIT];
      prescaler_select    <= reg_wdata[PRESCALE_LSB +: 2];
      rate_divisor_select <= reg_wdata[RATE_DIV_LSB +: 3];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      narrow_pulse_select <= INFRARED_CONFIG_RST[NARROW_LSB +: 2];
      infrared_enable     <= INFRARED_CONFIG_RST[IR_ENABLE_BIT];
    end else if (reg_write && reg_addr == INFRARED_CONFIG_OFS) begin
      narrow_pulse_select <= reg_wdata[NARROW_LSB +: 2];
      infrared_enable     <= reg_wdata[IR_ENABLE_BIT];
    end
  end

  // ==========================================================
  // read port: data one cycle after the strobe, unmapped reads zero
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (reg_addr == BAUD_RATE_CONFIG_OFS) begin
      rd_mux[CLK_SRC_BIT]         = clock_source_select;
      rd_mux[PRESCALE_LSB +: 2]   = prescaler_select;
      rd_mux[RATE_DIV_LSB +: 3]   = rate_divisor_select;
    end else if (reg_addr == INFRARED_CONFIG_OFS) begin
      rd_mux[NARROW_LSB +: 2]     = narrow_pulse_select;
      rd_mux[IR_ENABLE_BIT]       = infrared_enable;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= '0;
    end
  end

  // ==========================================================
  // pin synchronisers: crystal clock and infrared receive pin
  logic xtal_sync;
  logic ir_rx_sync;
  logic xtal_prev_reg;

  irb_sync u_sync_xtal (
    .clock  (clock),
    .resetn (resetn),
    .d      (crystal_osc_clock),
    .q      (xtal_sync)
  );

  irb_sync u_sync_irrx (
    .clock  (clock),
    .resetn (resetn),
    .d      (ir_rx_pin),
    .q      (ir_rx_sync)
  );

  // crystal rising edges become enables; crystal must run below half the bus clock
  always_ff @(posedge clock) begin
    if (!resetn) begin
      xtal_prev_reg <= 1'b0;
    end else begin
      xtal_prev_reg <= xtal_sync;
    end
  end

  logic src_en;
  assign src_en = clock_source_select ? 1'b1 : (xtal_sync & ~xtal_prev_reg);

  // ==========================================================
  // prescaler stage: one pulse per pd source enables
  logic [3:0] pre_cnt_reg;
  logic       pre_en;
  assign pre_en = src_en && (pre_cnt_reg == pd_of(prescaler_select) - 4'h1);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pre_cnt_reg <= '0;
    end else if (src_en) begin
      // a smaller new divisor would strand the count, so wrap on overshoot
      if (pre_cnt_reg >= pd_of(prescaler_select) - 4'h1) begin
        pre_cnt_reg <= '0;
      end else begin
        pre_cnt_reg <= pre_cnt_reg + 4'h1;
      end
    end
  end

  // rate divisor stage: 2**code prescaled pulses per 16x sample
  logic [6:0] rate_cnt_reg;
  logic [6:0] rate_last;
  logic       smp_en;
  assign rate_last = 7'((8'h01 << rate_divisor_select) - 8'h01);
  assign smp_en    = pre_en && (rate_cnt_reg >= rate_last);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rate_cnt_reg <= '0;
    end else if (pre_en) begin
      if (rate_cnt_reg >= rate_last) begin
        rate_cnt_reg <= '0;
      end else begin
        rate_cnt_reg <= rate_cnt_reg + 7'h01;
      end
    end
  end

  // half-sample enable for the 1/32 pulse slots: toggle mid way is too
  // costly at odd divisors, so the 1/32 slot rides on the prescaled pulse
  // at half rate_last when the divisor allows, else on the sample itself
  logic half_en;
  assign half_en = smp_en || (pre_en && rate_last != 7'h00 &&
                   rate_cnt_reg == (rate_last >> 1));

  // ==========================================================
  // 16x sample tick and bit tick shared by receiver and transmitter
  logic [3:0] os_cnt_reg;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      os_cnt_reg  <= '0;
      sample_tick <= 1'b0;
      bit_tick    <= 1'b0;
    end else begin
      sample_tick <= smp_en;
      bit_tick    <= smp_en && (os_cnt_reg == 4'(OVERSAMPLE - 1));
      if (smp_en) begin
        os_cnt_reg <= os_cnt_reg + 4'h1;
      end
    end
  end

  // ==========================================================
  // infrared encoder: a zero bit sends a narrow high pulse at bit start
  logic [5:0] slot_cnt_reg;
  logic       tx_prev_reg;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      slot_cnt_reg <= SUBTICKS;
      tx_prev_reg  <= 1'b1;
    end else if (smp_en && os_cnt_reg == 4'h0) begin
      slot_cnt_reg <= '0;
      tx_prev_reg  <= tx_serial;
    end else if (half_en && slot_cnt_reg != SUBTICKS) begin
      slot_cnt_reg <= slot_cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ir_tx_pin <= 1'b0;
    end else if (infrared_enable) begin
      ir_tx_pin <= !tx_prev_reg && (slot_cnt_reg < width_of(narrow_pulse_select));
    end else begin
      ir_tx_pin <= tx_serial;
    end
  end

  // ==========================================================
  // infrared decoder: a pulse seen in a bit marks a zero, stretched one bit
  logic [4:0] stretch_reg;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      stretch_reg <= '0;
    end else if (ir_rx_sync) begin
      stretch_reg <= 5'(OVERSAMPLE);
    end else if (smp_en && stretch_reg != 5'h00) begin
      stretch_reg <= stretch_reg - 5'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rx_serial <= 1'b1;
    end else if (infrared_enable) begin
      rx_serial <= (stretch_reg == 5'h00) && !ir_rx_sync;
    end else begin
      rx_serial <= ir_rx_sync;
    end
  end

endmodule : irb_baud_ir
`default_nettype wire

// ### core/irb_pkg.sv
// package for the infrared serial baud and infrared control block
// assumes a single 250 MHz clock and a plain strobe register port
package irb_pkg;

  // ==========================================================
  // register map (byte offsets on the plain register port)
  localparam logic [3:0] BAUD_RATE_CONFIG_OFS = 4'h0;
  localparam logic [3:0] INFRARED_CONFIG_OFS  = 4'h1;
  localparam int         ADDR_W               = 4;
  localparam int         DATA_W               = 8;

  // ==========================================================
  // baud_rate_config field positions
  localparam int RATE_DIV_LSB  = 0;   // rate_divisor_select, 3 bits
  localparam int PRESCALE_LSB  = 4;   // prescaler select lo/hi, 2 bits
  localparam int CLK_SRC_BIT   = 6;   // clock_source_select

  // infrared_config field positions
  localparam int NARROW_LSB    = 0;   // narrow pulse select lo/hi, 2 bits
  localparam int IR_ENABLE_BIT = 4;   // infrared_enable

  // ==========================================================
  // reset values
  localparam logic [7:0] BAUD_RATE_CONFIG_RST = 8'h00;
  localparam logic [7:0] INFRARED_CONFIG_RST  = 8'h00;

  // ==========================================================
  // divisor constants
  localparam int OVERSAMPLE      = 16;  // samples per bit
  localparam logic [3:0] PD_CODE0 = 4'h1;
  localparam logic [3:0] PD_CODE1 = 4'h3;
  localparam logic [3:0] PD_CODE2 = 4'h4;
  localparam logic [3:0] PD_CODE3 = 4'hd;

  // narrow pulse widths in 1/32 bit units
  localparam logic [5:0] PULSE_3_16 = 6'h06;
  localparam logic [5:0] PULSE_1_16 = 6'h02;
  localparam logic [5:0] PULSE_1_32 = 6'h01;
  localparam logic [5:0] SUBTICKS   = 6'h20;  // 1/32 slots per bit

endpackage : irb_pkg

// ### core/irb_sync.sv
// two flip-flop level synchroniser
// assumes the input comes from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module irb_sync
  import irb_pkg::*;
(
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic d,
  output var  logic q
);

  logic meta_reg;

  // ==========================================================
  // first stage is read only by the second stage
  always_ff @(posedge clock) begin
    if (!resetn) begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : irb_sync
`default_nettype wire

// ### testbench/irb_baud_ir_tb.sv
// self-checking bench for the baud and infrared control block
// assumes the checker is bound in and the peer drives the far-side pins
`timescale 1ns/10ps
`default_nettype none
module irb_baud_ir_tb
  import irb_pkg::*;
;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic [7:0]        exp_q[$];
  logic [7:0]        d;
  logic [7:0]        cfg_t[7] = '{8'h40, 8'h51, 8'h62, 8'h73, 8'h44, 8'h00, 8'h01};
  logic [15:0]       pd_t[4] = '{16'h0001, 16'h0003, 16'h0004, 16'h000d};
  logic [15:0]       w_t[4] = '{16'h000c, 16'h0004, 16'h000c, 16'h0002};
  logic [15:0]       per, ns, nb, nh, nr;
  logic              clock, resetn, reg_write, reg_read, tx_serial, fire, rd_q;
  logic              crystal_osc_clock, ir_rx_pin, sample_tick, bit_tick, ir_tx_pin, rx_serial;
  int                error_cnt, n_checks, seed, k;

  irb_baud_ir dut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .crystal_osc_clock(crystal_osc_clock),
    .tx_serial(tx_serial), .ir_rx_pin(ir_rx_pin), .sample_tick(sample_tick), .bit_tick(bit_tick),
    .ir_tx_pin(ir_tx_pin), .rx_serial(rx_serial));
  irb_ir_peer u_peer (.fire(fire), .crystal_osc_clock(crystal_osc_clock), .ir_rx_pin(ir_rx_pin));

  // ==========================================================
  // clock, compares, bus cycles
  always #2 clock = ~clock;
  task automatic chk_cnt(input string n, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk_cnt
  task automatic chk_rd(input logic [7:0] e, input logic [7:0] s);
    chk_cnt("reg_rdata", {8'h00, e}, {8'h00, s});
  endtask : chk_rd
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // strobes drop after one edge; callers never chain two of the same kind
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    reg_read <= 1'b0;
  endtask : rd
  task automatic wait_for(input logic use_bit);
    for (int i = 0; i < 30000; i++) begin
      @(posedge clock);
      if ((use_bit ? bit_tick : sample_tick) === 1'b1) return;
    end
    error_cnt++;
    $display("ERROR tick_wait expected 1 seen 0");
    end_of_test();
  endtask : wait_for
  // counts ticks and infrared high cycles over n cycles
  task automatic count(input logic [15:0] n);
    ns = 16'h0000;
    nb = 16'h0000;
    nh = 16'h0000;
    nr = 16'h0000;
    repeat (n) begin
      @(posedge clock);
      ns += {15'h0000, sample_tick};
      nb += {15'h0000, bit_tick};
      nh += {15'h0000, ir_tx_pin};
      nr += {15'h0000, ~rx_serial};
    end
  endtask : count
  // read data stands only in the cycle after the strobe
  always @(posedge clock) begin
    if (rd_q) chk_rd(exp_q.pop_front(), reg_rdata);
    rd_q <= reg_read & resetn;
  end

  // ==========================================================
  // main sequence
  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    tx_serial = 1'b1;
    fire = 1'b0;
    rd_q = 1'b0;
    seed = 85;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rd(BAUD_RATE_CONFIG_OFS, 8'h00);
    wr(4'h5, 8'hff);
    rd(INFRARED_CONFIG_OFS, 8'h00);
    // random settings through the field masks; unmapped places stay empty
    for (k = 0; k < 8; k++) begin
      d = 8'($random(seed));
      wr(BAUD_RATE_CONFIG_OFS, d);
      rd(BAUD_RATE_CONFIG_OFS, d & 8'h77);
      d = 8'($random(seed));
      wr(INFRARED_CONFIG_OFS, d);
      rd(INFRARED_CONFIG_OFS, d & 8'h13);
      wr(4'h2 + k[3:0], 8'($random(seed)));
      rd(4'h8 + k[3:0], 8'h00);
    end
    // one bit period holds 16 samples and one bit tick, on either source
    for (k = 0; k < 7; k++) begin
      wr(BAUD_RATE_CONFIG_OFS, cfg_t[k]);
      per = (cfg_t[k][6] ? 16'h0001 : 16'h0018) * pd_t[cfg_t[k][5:4]] << cfg_t[k][2:0];
      wait_for(1'b1);
      wait_for(1'b0);
      count(per * 16'h0010);
      chk_cnt("sample_tick", 16'h0010, ns);
      chk_cnt("bit_tick", 16'h0001, nb);
    end
    // zero bits at 64 cycles each: high time per bit for every pulse code
    wr(BAUD_RATE_CONFIG_OFS, 8'h42);
    rd(BAUD_RATE_CONFIG_OFS, 8'h42);
    for (k = 0; k < 4; k++) begin
      wr(INFRARED_CONFIG_OFS, 8'h10 | k[7:0]);
      tx_serial <= 1'b0;
      wait_for(1'b1);
      wait_for(1'b1);
      count(16'h0040);
      chk_cnt("ir_tx_pin", w_t[k], nh);
      tx_serial <= 1'b1;
    end
    // encoder off passes random data straight through, then a received pulse
    wr(INFRARED_CONFIG_OFS, 8'h03);
    repeat (64) begin
      @(posedge clock);
      tx_serial <= 1'($random(seed));
    end
    wr(INFRARED_CONFIG_OFS, 8'h10);
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
    count(16'h0080);
    // pulse of about eight cycles, then sixteen samples of four cycles; phase gives a few cycles of slack
    chk_cnt("rx_serial", 16'h0001, {15'h0000, (nr >= 16'h0042 && nr <= 16'h004a)});
    end_of_test();
  end
endmodule : irb_baud_ir_tb
`default_nettype wire

// ### testbench/irb_chk.sv
// checker for the baud and infrared control block
// assumes it is bound onto irb_baud_ir and sees its ports only
`timescale 1ns/10ps
`default_nettype none
module irb_chk
  import irb_pkg::*;
(
  input wire logic              clock,
  input wire logic              resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_write,
  input wire logic              reg_read,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              crystal_osc_clock,
  input wire logic              tx_serial,
  input wire logic              ir_rx_pin,
  input wire logic              sample_tick,
  input wire logic              bit_tick,
  input wire logic              ir_tx_pin,
  input wire logic              rx_serial
);
  // ==========================================================
  // shadow registers rebuilt from bus writes, never read from the design
  logic [7:0]  baud_reg;
  logic [7:0]  irc_reg;
  logic [11:0] stab_reg;
  logic [11:0] gap_reg;
  logic [4:0]  scnt_reg;
  logic        wr_reg;
  logic        bt_reg;
  logic [11:0] per;
  // sample period in bus cycles for the shadow setting when the bus clock is the source
  always_comb begin
    case (baud_reg[5:4])
      2'h0: per = 12'h001;
      2'h1: per = 12'h003;
      2'h2: per = 12'h004;
      default: per = 12'h00d;
    endcase
    per = per << baud_reg[2:0];
  end
  // stab counts cycles since the last write, so rate checks skip the settling span
  always_ff @(posedge clock) begin
    if (!resetn) begin
      baud_reg <= 8'h00;
      irc_reg <= 8'h00;
      wr_reg <= 1'b0;
      stab_reg <= 12'h000;
    end else begin
      if (reg_write && reg_addr == BAUD_RATE_CONFIG_OFS) baud_reg <= reg_wdata & 8'h77;
      if (reg_write && reg_addr == INFRARED_CONFIG_OFS) irc_reg <= reg_wdata & 8'h13;
      wr_reg <= wr_reg | reg_write;
      stab_reg <= reg_write ? 12'h000 : stab_reg + {11'h000, ~&stab_reg};
    end
  end
  // gap since last sample tick, sample ticks since last bit tick
  always_ff @(posedge clock) begin
    gap_reg <= sample_tick ? 12'h000 : gap_reg + 12'h001;
    scnt_reg <= bit_tick ? 5'h00 : scnt_reg + {4'h0, sample_tick};
    bt_reg <= resetn && !reg_write && (bt_reg || bit_tick);
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  AST_RST_ZERO: assert property (reg_read && !wr_reg |=> reg_rdata == 8'h00)
    else $error("register not clear after reset");
  AST_BAUD_RB: assert property (reg_read && reg_addr == BAUD_RATE_CONFIG_OFS |=> reg_rdata == baud_reg)
    else $error("baud setting read back wrong");
  AST_IR_RB: assert property (reg_read && reg_addr == INFRARED_CONFIG_OFS |=> reg_rdata == irc_reg)
    else $error("infrared setting read back wrong");
  AST_TICK_GAP: assert property (sample_tick && baud_reg[6] && stab_reg > {per[10:0], 1'b0} + 12'h008
    |-> gap_reg == per - 12'h001) else $error("sample tick period wrong");
  AST_BIT_16: assert property (bit_tick && bt_reg |-> scnt_reg + {4'h0, sample_tick} == 5'h10)
    else $error("bit tick not every 16 samples");
  AST_XTAL_HOLD: assert property ((!baud_reg[6] && stab_reg > 12'h010 && $stable(crystal_osc_clock))[*8]
    |-> !sample_tick)
    else $error("tick without crystal edge");
  AST_IR_OFF: assert property ($past(resetn) && !irc_reg[4] && !$past(irc_reg[4])
    |-> ir_tx_pin == $past(tx_serial)) else $error("disabled encoder not transparent");
  AST_RX_DEC: assert property (irc_reg[4] && $rose(ir_rx_pin) |-> ##[1:6] !rx_serial)
    else $error("received pulse not decoded");
endmodule : irb_chk
bind irb_baud_ir irb_chk u_chk (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .crystal_osc_clock(crystal_osc_clock),
  .tx_serial(tx_serial), .ir_rx_pin(ir_rx_pin), .sample_tick(sample_tick), .bit_tick(bit_tick),
  .ir_tx_pin(ir_tx_pin), .rx_serial(rx_serial));
`default_nettype wire

// ### testbench/irb_ir_peer.sv
// far side model: crystal oscillator pin and infrared receiver
// assumes the bench pulses fire once per received zero bit
`timescale 1ns/10ps
`default_nettype none
module irb_ir_peer (
  input  wire logic fire,
  output var  logic crystal_osc_clock,
  output var  logic ir_rx_pin
);
  // ==========================================================
  // crystal runs free at 24 bus cycles, offset so no edge meets the bus clock
  initial begin
    crystal_osc_clock = 1'b0;
    #1.3;
    forever #48 crystal_osc_clock = ~crystal_osc_clock;
  end
  // a zero bit arrives as one short light pulse; the line idles low
  initial ir_rx_pin = 1'b0;
  always @(posedge fire) begin
    ir_rx_pin = 1'b1;
    #30.7;
    ir_rx_pin = 1'b0;
  end
endmodule : irb_ir_peer
`default_nettype wire
